// ===== directional_overcurrent_pkg.sv
// Package for the directional overcurrent decision block.
// Assumes all users import it whole.
`default_nettype none
package directional_overcurrent_pkg;
  localparam int MAG_W = 16;
  localparam int ANG_W = 10;
  localparam int ANGX_W = 12;
  typedef struct packed {
    logic [MAG_W-1:0] mag;
    logic signed [ANG_W-1:0] ang;
  } phasor_t;
  typedef enum logic [1:0] {
    NON_DIRECTIONAL,
    FORWARD,
    BACKWARD
  } direction_t;
  typedef enum logic {
    SOLIDLY_EARTHED,
    ISOLATED
  } network_t;
  typedef enum logic {
    FUNDAMENTAL,
    RMS
  } input_type_t;
  typedef enum logic [1:0] {
    POL_NONE,
    POL_LOOP,
    POL_POSSEQ,
    POL_MEMORY
  } pol_src_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SCAN,
    ST_DECIDE
  } scan_state_t;
  // Byte offsets on the Wishbone slave
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ANGLE_OFS = 8'h04;
  localparam logic [7:0] RATED_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  // Control fields
  localparam int EN_BIT = 0;
  localparam int NET_BIT = 1;
  localparam int DIR_LSB = 2;
  localparam int NDVTS_BIT = 4;
  localparam int ITYPE_BIT = 5;
  // Angle and rated fields
  localparam int HW_LSB = 0;
  localparam int CA_LSB = 8;
  localparam int RI_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  localparam logic [6:0] HW_RST = 7'h3c;
  localparam logic signed [7:0] CA_RST = 8'sh3c;
  localparam logic [6:0] HW_MIN = 7'h0a;
  localparam logic [6:0] HW_MAX = 7'h55;
  localparam logic signed [7:0] CA_MIN = -8'sh5a;
  localparam logic signed [7:0] CA_MAX = 8'sh5a;
  localparam logic [15:0] RATED_U_RST = 16'h4000;
  localparam logic [15:0] RATED_I_RST = 16'h4000;
  // Qualification in percent of rated
  localparam logic [31:0] U_MIN_PCT = 32'h0000_0005;
  localparam logic [31:0] I_MIN_PCT = 32'h0000_0008;
  localparam logic [31:0] PCT_FULL = 32'h0000_0064;
  localparam logic signed [ANGX_W-1:0] HALF_TURN = 12'sh0b4;
  localparam logic signed [ANGX_W-1:0] FULL_TURN = 12'sh168;
  localparam logic [2:0] LAST_PP = 3'h2;
  localparam logic [2:0] LAST_ALL = 3'h5;
endpackage
`default_nettype wire

// ===== directional_overcurrent_function.sv
// Directional decision front end of a three-phase directional overcurrent function.
// Assumes measurement phasors and status inputs come from logic on clk_sys_in,
// a one-cycle sample strobe per new set, and a classic Wishbone master.
// Behaviour
// - Select loop with smallest impedance
// - Qualify: voltage over 5%, current 8%
// - Isolated network scans phase-to-phase loops only
// - Enable status needs voltage and current
// - Angle of voltage against current reference
// - AND all enabling statuses together
// - Decide angle inside operating range
// - Half-width 10..85, characteristic -90..90
// - Direction nondirectional, forward or backward
// - Low loop voltage uses positive sequence
// - Else use memorised pre-fault voltage
// - Switch-onto-fault forces result, no delay
// - Supervision fail with flag goes nondirectional
// - Supervision fail without flag blocks function
// - Result true: in range, nondirectional, onto-fault
// - Enable setting switches function on/off
// - Outputs: three starts, general start, trip
// - Route RMS or fundamental currents
// - Overcurrent stage gated; fundamental by default
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`default_nettype none
module directional_overcurrent_function (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic sample_valid_in,
  input wire directional_overcurrent_pkg::phasor_t [2:0] phase_u_in,
  input wire directional_overcurrent_pkg::phasor_t [2:0] ll_u_in,
  input wire directional_overcurrent_pkg::phasor_t [2:0] phase_i_in,
  input wire directional_overcurrent_pkg::phasor_t [2:0] ll_i_in,
  input wire directional_overcurrent_pkg::phasor_t pos_u_in,
  input wire logic [2:0][directional_overcurrent_pkg::MAG_W-1:0] rms_i_in,
  input wire logic block_in,
  input wire logic voltage_supervision_fail_in,
  input wire logic switch_onto_fault_condition_in,
  input wire logic [2:0] oc_start_in,
  input wire logic oc_trip_in,
  output logic [2:0][directional_overcurrent_pkg::MAG_W-1:0] oc_current_out,
  output logic oc_enable_out,
  output logic [2:0] phase_start_out,
  output logic general_start_out,
  output logic trip_out,
  output logic dir_result_out,
  output logic dir_enable_out,
  output logic [2:0] sel_loop_out,
  output logic signed [directional_overcurrent_pkg::ANG_W-1:0] loop_angle_out
);
  import directional_overcurrent_pkg::*;

  function automatic logic [31:0] merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic pct_over(
    input logic [MAG_W-1:0] mag,
    input logic [MAG_W-1:0] rated,
    input logic [31:0] pct,
    input logic allow_eq
  );
    logic [31:0] a;
    logic [31:0] b;
    a = 32'(mag) * PCT_FULL;
    b = 32'(rated) * pct;
    return allow_eq ? (a >= b) : (a > b);
  endfunction

  // Cross products avoid a divider: Ua/Ia < Ub/Ib
  function automatic logic imp_less(
    input logic [MAG_W-1:0] ua,
    input logic [MAG_W-1:0] ia,
    input logic [MAG_W-1:0] ub,
    input logic [MAG_W-1:0] ib
  );
    return (32'(ua) * 32'(ib)) < (32'(ub) * 32'(ia));
  endfunction

  function automatic logic signed [ANGX_W-1:0] ext(input logic signed [ANG_W-1:0] a);
    return {{(ANGX_W-ANG_W){a[ANG_W-1]}}, a};
  endfunction

  // Folds -540..539 into -180..179
  function automatic logic signed [ANG_W-1:0] wrap(input logic signed [ANGX_W-1:0] a);
    logic signed [ANGX_W-1:0] r;
    r = a;
    if (r >= HALF_TURN) begin
      r = r - FULL_TURN;
    end else if (r < -HALF_TURN) begin
      r = r + FULL_TURN;
    end
    return r[ANG_W-1:0];
  endfunction

  // Positive sequence angle to loop voltage angle
  function automatic logic signed [ANGX_W-1:0] pos_shift(input logic [2:0] idx);
    case (idx)
      3'h0: return 12'sd30;
      3'h1: return -12'sd90;
      3'h2: return 12'sd150;
      3'h4: return -12'sd120;
      3'h5: return 12'sd120;
      default: return 12'sd0;
    endcase
  endfunction

  logic fn_enable;
  network_t network_type_setting;
  direction_t direction_setting;
  logic non_directional_on_supervision_flag;
  input_type_t current_input_type;
  logic [6:0] operating_half_width;
  logic signed [7:0] characteristic_angle;
  logic [MAG_W-1:0] rated_u;
  logic [MAG_W-1:0] rated_i;

  scan_state_t state;
  logic [2:0] scan_idx;
  phasor_t u_snap [0:5];
  phasor_t i_snap [0:5];
  phasor_t pos_snap;
  logic signed [ANG_W-1:0] mem_ang [0:5];
  logic [5:0] mem_valid;
  logic best_valid;
  logic [2:0] best_idx;
  phasor_t best_u;
  phasor_t best_i;
  logic sel_valid;
  logic pol_ok;
  pol_src_t pol_src;
  logic blocked;

  wire bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire bus_wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;
  wire wr_ctrl = bus_wr & (wb_adr_in == CTRL_OFS);
  wire wr_angle = bus_wr & (wb_adr_in == ANGLE_OFS);
  wire wr_rated = bus_wr & (wb_adr_in == RATED_OFS);

  wire [31:0] ctrl_word = {26'h0, current_input_type, non_directional_on_supervision_flag,
    direction_setting, network_type_setting, fn_enable};
  wire [31:0] angle_word = {16'h0, characteristic_angle, 1'b0, operating_half_width};
  wire [31:0] rated_word = {rated_i, rated_u};
  wire [31:0] status_word = {6'h0, loop_angle_out, 8'h0, pol_src, blocked,
    dir_result_out, dir_enable_out, sel_loop_out};
  wire [31:0] next_ctrl = merge(ctrl_word, wb_dat_in, wb_sel_in);
  wire [31:0] next_angle = merge(angle_word, wb_dat_in, wb_sel_in);
  wire [31:0] next_rated = merge(rated_word, wb_dat_in, wb_sel_in);
  wire [31:0] rd_data = (wb_adr_in == CTRL_OFS) ? ctrl_word :
    (wb_adr_in == ANGLE_OFS) ? angle_word :
    (wb_adr_in == RATED_OFS) ? rated_word :
    (wb_adr_in == STATUS_OFS) ? status_word : 32'h0;

  // Out-of-range half-width and characteristic angle settings are clamped to the nearest legal value
  wire [6:0] hw_wr = next_angle[HW_LSB +: 7];
  wire signed [7:0] ca_wr = next_angle[CA_LSB +: 8];
  wire [6:0] next_half_width = (hw_wr < HW_MIN) ? HW_MIN :
    (hw_wr > HW_MAX) ? HW_MAX : hw_wr;
  wire signed [7:0] next_char_angle = (ca_wr < CA_MIN) ? CA_MIN :
    (ca_wr > CA_MAX) ? CA_MAX : ca_wr;
  wire [1:0] dir_wr = next_ctrl[DIR_LSB +: 2];
  // Unused code 3 keeps the documented default
  wire direction_t next_direction = (dir_wr == 2'h0) ? NON_DIRECTIONAL :
    (dir_wr == 2'h2) ? BACKWARD : FORWARD;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= bus_req;
      if (bus_req) begin
        wb_dat_out <= rd_data;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      fn_enable <= CTRL_RST[EN_BIT];
      network_type_setting <= SOLIDLY_EARTHED;
      direction_setting <= FORWARD;
      non_directional_on_supervision_flag <= CTRL_RST[NDVTS_BIT];
      current_input_type <= FUNDAMENTAL;
    end else if (wr_ctrl) begin
      fn_enable <= next_ctrl[EN_BIT];
      network_type_setting <= network_t'(next_ctrl[NET_BIT]);
      direction_setting <= next_direction;
      non_directional_on_supervision_flag <= next_ctrl[NDVTS_BIT];
      current_input_type <= input_type_t'(next_ctrl[ITYPE_BIT]);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      operating_half_width <= HW_RST;
      characteristic_angle <= CA_RST;
      rated_u <= RATED_U_RST;
      rated_i <= RATED_I_RST;
    end else begin
      if (wr_angle) begin
        operating_half_width <= next_half_width;
        characteristic_angle <= next_char_angle;
      end
      if (wr_rated) begin
        rated_u <= next_rated[0 +: MAG_W];
        rated_i <= next_rated[RI_LSB +: MAG_W];
      end
    end
  end

  // Loop scan, one loop per cycle
  wire phasor_t cu = u_snap[scan_idx];
  wire phasor_t ci = i_snap[scan_idx];
  wire cand_i_ok = pct_over(ci.mag, rated_i, I_MIN_PCT, 1'b1);
  wire cand_u_ok = pct_over(cu.mag, rated_u, U_MIN_PCT, 1'b0);
  wire cand_better = ~best_valid | imp_less(cu.mag, ci.mag, best_u.mag, best_i.mag);
  wire take_cand = cand_i_ok & cand_better;
  wire [2:0] last_idx = (network_type_setting == ISOLATED) ? LAST_PP : LAST_ALL;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      scan_idx <= 3'h0;
      best_valid <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (sample_valid_in) begin
            state <= ST_SCAN;
            scan_idx <= 3'h0;
            best_valid <= 1'b0;
          end
        end
        ST_SCAN: begin
          if (take_cand) begin
            best_valid <= 1'b1;
          end
          if (scan_idx == last_idx) begin
            state <= ST_DECIDE;
          end else begin
            scan_idx <= scan_idx + 3'h1;
          end
        end
        ST_DECIDE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (state == ST_IDLE && sample_valid_in) begin
      for (int k = 0; k < 3; k++) begin
        u_snap[k] <= ll_u_in[k];
        i_snap[k] <= ll_i_in[k];
        u_snap[k+3] <= phase_u_in[k];
        i_snap[k+3] <= phase_i_in[k];
      end
      pos_snap <= pos_u_in;
    end
    if (state == ST_SCAN && take_cand) begin
      best_idx <= scan_idx;
      best_u <= cu;
      best_i <= ci;
    end
  end

  // Memory follows only healthy voltages, so a collapse keeps the pre-fault angle
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      mem_valid <= 6'h0;
    end else if (state == ST_SCAN && cand_u_ok) begin
      mem_valid[scan_idx] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (state == ST_SCAN && cand_u_ok) begin
      mem_ang[scan_idx] <= cu.ang;
    end
  end

  // Polarising quantity for the selected loop
  wire loop_u_ok = pct_over(best_u.mag, rated_u, U_MIN_PCT, 1'b0);
  wire pos_u_ok = pct_over(pos_snap.mag, rated_u, U_MIN_PCT, 1'b0);
  wire mem_ok = mem_valid[best_idx];
  wire signed [ANG_W-1:0] pos_ang = wrap(ext(pos_snap.ang) + pos_shift(best_idx));
  wire signed [ANG_W-1:0] pol_ang = loop_u_ok ? best_u.ang :
    pos_u_ok ? pos_ang : mem_ang[best_idx];
  wire pol_src_t next_pol_src = loop_u_ok ? POL_LOOP :
    pos_u_ok ? POL_POSSEQ : mem_ok ? POL_MEMORY : POL_NONE;
  wire signed [ANG_W-1:0] next_loop_ang = wrap(ext(pol_ang) - ext(best_i.ang));

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      sel_valid <= 1'b0;
      pol_ok <= 1'b0;
      pol_src <= POL_NONE;
      sel_loop_out <= 3'h0;
      loop_angle_out <= '0;
    end else if (state == ST_DECIDE) begin
      sel_valid <= best_valid;
      pol_ok <= best_valid & (next_pol_src != POL_NONE);
      pol_src <= best_valid ? next_pol_src : POL_NONE;
      sel_loop_out <= best_idx;
      loop_angle_out <= next_loop_ang;
    end
  end

  // Range check runs on live settings against the held angle
  wire signed [ANG_W-1:0] fwd_diff = wrap(ext(loop_angle_out) -
    {{(ANGX_W-8){characteristic_angle[7]}}, characteristic_angle});
  wire signed [ANG_W-1:0] dir_diff = (direction_setting == BACKWARD) ?
    wrap(ext(fwd_diff) - HALF_TURN) : fwd_diff;
  wire [ANG_W-1:0] abs_diff = dir_diff[ANG_W-1] ? ANG_W'(-dir_diff) : dir_diff;
  wire in_range = abs_diff <= {3'h0, operating_half_width};

  wire vts_non_directional = voltage_supervision_fail_in & non_directional_on_supervision_flag;
  wire next_blocked = ~fn_enable | block_in |
    (voltage_supervision_fail_in & ~non_directional_on_supervision_flag);
  wire non_directional_mode = (direction_setting == NON_DIRECTIONAL) | vts_non_directional;
  wire next_dir_enable = sel_valid & pol_ok & ~voltage_supervision_fail_in;
  // Onto-fault bypasses the angle path, so it lands on the next edge
  wire next_dir_result = switch_onto_fault_condition_in | non_directional_mode |
    (next_dir_enable & in_range);
  wire next_oc_enable = next_dir_result & ~next_blocked;
  wire [2:0] next_start = oc_start_in & {3{next_oc_enable}};

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      blocked <= 1'b1;
      dir_enable_out <= 1'b0;
      dir_result_out <= 1'b0;
      oc_enable_out <= 1'b0;
      phase_start_out <= 3'h0;
      general_start_out <= 1'b0;
      trip_out <= 1'b0;
      oc_current_out <= '0;
    end else begin
      blocked <= next_blocked;
      dir_enable_out <= next_dir_enable;
      dir_result_out <= next_dir_result;
      oc_enable_out <= next_oc_enable;
      phase_start_out <= next_start;
      general_start_out <= |next_start;
      trip_out <= oc_trip_in & next_oc_enable;
      for (int k = 0; k < 3; k++) begin
        oc_current_out[k] <= (current_input_type == RMS) ? rms_i_in[k] :
          phase_i_in[k].mag;
      end
    end
  end

endmodule // directional_overcurrent_function
`default_nettype wire

// ===== directional_overcurrent_props.sv
// Checker for the directional decision block.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module directional_overcurrent_props
  import directional_overcurrent_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic block_in,
  input wire logic voltage_supervision_fail_in,
  input wire logic switch_onto_fault_condition_in,
  input wire logic [2:0] oc_start_in,
  input wire logic oc_trip_in,
  input wire logic oc_enable_out,
  input wire logic [2:0] phase_start_out,
  input wire logic general_start_out,
  input wire logic trip_out,
  input wire logic dir_result_out,
  input wire logic dir_enable_out,
  input wire logic [2:0] sel_loop_out,
  input wire logic signed [ANG_W-1:0] loop_angle_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  chk_start_gate:
    assert property (!oc_enable_out && !$past(oc_enable_out) |-> !phase_start_out && !general_start_out && !trip_out)
      else $error("start seen without enable");
  chk_start_pass:
    assert property (oc_enable_out && $past(oc_enable_out) |->
      phase_start_out == $past(oc_start_in) && general_start_out == (|$past(oc_start_in)))
      else $error("starts not passed on");
  chk_trip_pass:
    assert property (oc_enable_out && $past(oc_enable_out) |-> trip_out == $past(oc_trip_in))
      else $error("trip not passed on");
  chk_block_gate:
    assert property (block_in |=> !oc_enable_out)
      else $error("enable while blocked");
  chk_sotf_force:
    assert property (switch_onto_fault_condition_in |=> dir_result_out)
      else $error("onto-fault did not force result");
  chk_vts_drop:
    assert property (voltage_supervision_fail_in |=> !dir_enable_out)
      else $error("direction enabled under supervision fail");
  chk_oc_needs_dir:
    assert property (oc_enable_out |-> dir_result_out)
      else $error("stage enabled without direction");
  chk_loop_code:
    assert property (sel_loop_out <= 3'h5 && loop_angle_out >= -10'sh0b4 && loop_angle_out <= 10'sh0b3)
      else $error("loop code or angle out of span");
endmodule // directional_overcurrent_props
bind directional_overcurrent_function directional_overcurrent_props u_props (.clk_sys_in, .srst_in,
  .block_in, .voltage_supervision_fail_in, .switch_onto_fault_condition_in, .oc_start_in, .oc_trip_in,
  .oc_enable_out, .phase_start_out, .general_start_out, .trip_out, .dir_result_out, .dir_enable_out,
  .sel_loop_out, .loop_angle_out);
`default_nettype wire

// ===== directional_overcurrent_partner.sv
// Far-side model: measurement source and downstream overcurrent stage.
// Assumes the bench calls sample() right after a rising clock edge.
`default_nettype none
module directional_overcurrent_partner
  import directional_overcurrent_pkg::*;
#(parameter logic [15:0] START_LVL = 16'h1000)
(
  input wire logic clk_in,
  input wire logic [2:0][MAG_W-1:0] oc_current_in,
  output logic sample_valid_out,
  output phasor_t [2:0] phase_u_out,
  output phasor_t [2:0] ll_u_out,
  output phasor_t [2:0] phase_i_out,
  output phasor_t [2:0] ll_i_out,
  output phasor_t pos_u_out,
  output logic [2:0][MAG_W-1:0] rms_i_out,
  output logic [2:0] oc_start_out,
  output logic oc_trip_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Stage picks up at a fixed level; its timers are out of scope here
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      oc_start_out[k] = oc_current_in[k] >= START_LVL;
    end
  end
  assign oc_trip_out = |oc_start_out;
  // Healthy L2/L3, L1 carries the fault current
  initial begin
    sample_valid_out = 1'b0;
    phase_u_out = '{'{16'h3000, 10'sh078}, '{16'h3000, -10'sh078}, '{16'h1000, 10'sh000}};
    ll_u_out = '{'{16'h5000, 10'sh096}, '{16'h5000, -10'sh05a}, '{16'h5000, 10'sh01e}};
    phase_i_out = '{'{16'h0100, 10'sh000}, '{16'h0100, 10'sh000}, '{16'h2000, 10'sh000}};
    ll_i_out = '{'{16'h0100, 10'sh000}, '{16'h0100, 10'sh000}, '{16'h1000, 10'sh000}};
    pos_u_out = '{16'h3000, 10'sh01e};
    rms_i_out = '{16'h3333, 16'h2222, 16'h1111};
  end
  // Sets are spaced 12 cycles, above the minimum the block needs
  task automatic sample(input logic [15:0] um, input logic signed [9:0] ua, input logic [15:0] pm,
                        input logic [15:0] li);
    phase_u_out[0] <= '{um, ua};
    pos_u_out.mag <= pm;
    ll_i_out[0].mag <= li;
    sample_valid_out <= 1'b1;
    @(posedge clk_in);
    sample_valid_out <= 1'b0;
    repeat (11) @(posedge clk_in);
  endtask
endmodule // directional_overcurrent_partner
`default_nettype wire

// ===== directional_overcurrent_function_tb.sv
// Testbench for the directional decision block.
// Assumes the far-side model and the bound checker are compiled with it.
`default_nettype none
module directional_overcurrent_function_tb
  import directional_overcurrent_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [31:0] wb_dat_in = 32'h0;
  logic block_in = 1'b0;
  logic voltage_supervision_fail_in = 1'b0;
  logic switch_onto_fault_condition_in = 1'b0;
  logic [31:0] wb_dat_out, rd;
  logic wb_ack_out, sample_valid_in, oc_trip_in, oc_enable_out, general_start_out, trip_out;
  logic dir_result_out, dir_enable_out;
  phasor_t [2:0] phase_u_in, ll_u_in, phase_i_in, ll_i_in;
  phasor_t pos_u_in;
  logic [2:0][MAG_W-1:0] rms_i_in, oc_current_out;
  logic [2:0] oc_start_in, phase_start_out, sel_loop_out;
  logic signed [ANG_W-1:0] loop_angle_out;
  int error_cnt = 0;
  int num_checks = 0;
  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  directional_overcurrent_function u_dut (.clk_sys_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in(4'hf), .wb_dat_in, .wb_dat_out, .wb_ack_out, .sample_valid_in, .phase_u_in,
    .ll_u_in, .phase_i_in, .ll_i_in, .pos_u_in, .rms_i_in, .block_in, .voltage_supervision_fail_in,
    .switch_onto_fault_condition_in, .oc_start_in, .oc_trip_in, .oc_current_out, .oc_enable_out,
    .phase_start_out, .general_start_out, .trip_out, .dir_result_out, .dir_enable_out, .sel_loop_out,
    .loop_angle_out);
  directional_overcurrent_partner u_far (.clk_in(clk_sys_in), .oc_current_in(oc_current_out),
    .sample_valid_out(sample_valid_in), .phase_u_out(phase_u_in), .ll_u_out(ll_u_in),
    .phase_i_out(phase_i_in), .ll_i_out(ll_i_in), .pos_u_out(pos_u_in), .rms_i_out(rms_i_in),
    .oc_start_out(oc_start_in), .oc_trip_out(oc_trip_in));
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= adr;
    wb_dat_in <= wd;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    chk("wb_ack_wait", 32'h2, 32'(n));
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
  endtask
  task rchk(input string what, input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(what, exp, rd & mask);
  endtask
  task clamp(input logic [31:0] w, input logic [31:0] e);
    wb(1'b1, ANGLE_OFS, w);
    rchk("angle_reg", ANGLE_OFS, 32'hffff, e);
  endtask
  task outs(input logic r, input logic e);
    chk("dir_result", {31'h0, r}, {31'h0, dir_result_out});
    chk("oc_enable", {31'h0, e}, {31'h0, oc_enable_out});
  endtask
  task ang_case(input logic [3:0] ctrl, input logic signed [9:0] a, input logic e);
    wb(1'b1, CTRL_OFS, {28'h0, ctrl});
    u_far.sample(16'h1000, a, 16'h3000, 16'h1000);
    outs(e, e);
  endtask
  task set_ctrl(input logic [31:0] v);
    wb(1'b1, CTRL_OFS, v);
    repeat (2) @(posedge clk_sys_in);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    error_cnt++;
    $display("[ERR] watchdog expected done seen hang");
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    outs(1'b0, 1'b0);
    rchk("ctrl", CTRL_OFS, 32'h3f, 32'h4);
    rchk("angle_reg", ANGLE_OFS, 32'hffff, 32'h3c3c);
    rchk("rated", RATED_OFS, 32'hffffffff, 32'h40004000);
    rchk("unmapped", 8'h10, 32'hffffffff, 32'h0);
    clamp(32'h9c05, 32'ha60a);
    clamp(32'h6456, 32'h5a55);
    clamp(32'h3c3c, 32'h3c3c);
    $display("test registers done");
    // Window edges around 60 with half width 60; code 3 acts as forward
    ang_case(4'h5, 10'sh078, 1'b1);
    ang_case(4'h5, 10'sh079, 1'b0);
    ang_case(4'h5, -10'sh001, 1'b0);
    ang_case(4'h9, -10'sh03c, 1'b1);
    ang_case(4'h9, -10'sh03b, 1'b0);
    ang_case(4'h9, -10'sh0b4, 1'b1);
    ang_case(4'h1, -10'sh03b, 1'b1);
    ang_case(4'hd, 10'sh078, 1'b1);
    chk("sel_loop", 32'h3, {29'h0, sel_loop_out});
    chk("angle", 32'h78, {22'h0, loop_angle_out});
    chk("oc_current", 32'h2000, {16'h0, oc_current_out[0]});
    chk("phase_start", 32'h1, {29'h0, phase_start_out});
    chk("gen_trip", 32'h3, {30'h0, general_start_out, trip_out});
    $display("test direction done");
    set_ctrl(32'h7);
    u_far.sample(16'h1000, 10'sh032, 16'h3000, 16'h1000);
    chk("sel_loop", 32'h0, {29'h0, sel_loop_out});
    chk("angle", 32'h1e, {22'h0, loop_angle_out});
    u_far.sample(16'h1000, 10'sh032, 16'h3000, 16'h051e);
    chk("dir_enable", 32'h0, {31'h0, dir_enable_out});
    chk("oc_enable", 32'h0, {31'h0, oc_enable_out});
    u_far.sample(16'h1000, 10'sh032, 16'h3000, 16'h051f);
    chk("dir_enable", 32'h1, {31'h0, dir_enable_out});
    $display("test loops done");
    // Voltage edge at 5 percent, then fallback to memory
    set_ctrl(32'h5);
    u_far.sample(16'h0334, 10'sh014, 16'h3000, 16'h0100);
    chk("angle", 32'h14, {22'h0, loop_angle_out});
    u_far.sample(16'h0333, 10'sh014, 16'h3000, 16'h0100);
    chk("angle", 32'h1e, {22'h0, loop_angle_out});
    u_far.sample(16'h0100, 10'sh000, 16'h0100, 16'h0100);
    chk("angle", 32'h14, {22'h0, loop_angle_out});
    rchk("status", STATUS_OFS, 32'hffffffff, 32'h001400db);
    $display("test polarising done");
    set_ctrl(32'h9);
    outs(1'b0, 1'b0);
    switch_onto_fault_condition_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    outs(1'b1, 1'b1);
    switch_onto_fault_condition_in <= 1'b0;
    voltage_supervision_fail_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk("oc_enable", 32'h0, {31'h0, oc_enable_out});
    set_ctrl(32'h19);
    chk("oc_enable", 32'h1, {31'h0, oc_enable_out});
    voltage_supervision_fail_in <= 1'b0;
    block_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk("oc_enable", 32'h0, {31'h0, oc_enable_out});
    block_in <= 1'b0;
    set_ctrl(32'h18);
    chk("oc_enable", 32'h0, {31'h0, oc_enable_out});
    $display("test overrides done");
    set_ctrl(32'h21);
    chk("oc_current", 32'h3333, {16'h0, oc_current_out[2]});
    chk("phase_start", 32'h7, {29'h0, phase_start_out});
    $display("test input type done");
    stop_test();
  end
endmodule // directional_overcurrent_function_tb
`default_nettype wire
